// ---- io_pins_map.vh ----
`ifndef IO_PINS_MAP_VH
`define IO_PINS_MAP_VH

// Register byte offsets
`define OFS_LEVEL_AB     12'h00D
`define OFS_LEVEL_CD     12'h01D
`define OFS_DRIVE_AB     12'h00C
`define OFS_DRIVE_CD     12'h01C
`define OFS_CHANGE_AB    12'h004
`define OFS_CHANGE_CD    12'h014
`define OFS_FUNC_A       12'h030
`define OFS_FUNC_B       12'h034
`define OFS_FUNC_C       12'h038
`define OFS_FUNC_D       12'h03C
`define OFS_CTRL         12'h040

// Control register fields
`define CTRL_DET_EN_LSB  0
`define CTRL_FLOW_LSB    4

// Pin function codes
`define CODE_INPUT       2'h0
`define CODE_GPO         2'h1
`define CODE_CLK_A       2'h2
`define CODE_CLK_B       2'h3

// Reset values
`define FUNC_RESET       8'h00
`define DRIVE_RESET      8'h00
`define CTRL_RESET       8'h00

// Change detector sampling
`define CLK_HZ           50000000
`define SAMPLE_HZ        38400
`define SAMPLE_DIV       ((`CLK_HZ) / (`SAMPLE_HZ))

`endif

// ---- uart_multifunction_io_pins.v ----
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "io_pins_map.vh"

module uart_multifunction_io_pins (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [15:0] pinIn,
    output reg  [15:0] pinOut,
    output reg  [15:0] pinOe_n,
    input  wire [3:0]  txClk1x,
    input  wire [3:0]  txClk16x,
    input  wire [3:0]  rxClk1x,
    input  wire [3:0]  rxClk16x,
    input  wire [1:0]  timerOut,
    output reg  [3:0]  txClkIn,
    output reg  [3:0]  txClkAltIn,
    output reg  [3:0]  rxClkIn,
    output reg  [3:0]  ctsIn,
    output reg  [1:0]  timerClkIn,
    output reg  [1:0]  changeBid
);

// ------------------------------------------------------------
// Registers
// ------------------------------------------------------------
reg [7:0]  funcQ [0:3];
reg [7:0]  driveQ [0:1];
reg [7:0]  ctrlQ;
reg [15:0] pinSync1Q;
reg [15:0] pinSync2Q;
reg [7:0]  changeQ;
reg [7:0]  stableQ;
reg [7:0]  candQ;
reg [15:0] divQ;
wire       tick = (divQ == 16'h0000);
// Reload value kept 32 bits wide so the cut to the divider width is explicit
localparam [31:0] DIV_LAST = `SAMPLE_DIV - 1;

// Level register view: chan0 pins -> bits 0,1,4,5; chan1 -> 2,3,6,7
function [7:0] levelMap;
    input [7:0] p;
    begin
        levelMap = {p[7], p[6], p[3], p[2], p[5], p[4], p[1], p[0]};
    end
endfunction

// Detector inputs: pins 0 and 1 of each channel of a pair
wire [7:0] detPins = {pinSync2Q[13], pinSync2Q[12], pinSync2Q[9], pinSync2Q[8],
                      pinSync2Q[5], pinSync2Q[4], pinSync2Q[1], pinSync2Q[0]};

wire [7:0] levelAb = levelMap(pinSync2Q[7:0]);
wire [7:0] levelCd = levelMap(pinSync2Q[15:8]);

// ------------------------------------------------------------
// APB slave
// ------------------------------------------------------------
wire acc = psel && penable && !pready;
wire wr = acc && pwrite;
wire rd = acc && !pwrite;

always @(posedge ref_clk) begin
    if (!nrst) begin
        funcQ[0] <= `FUNC_RESET;
        funcQ[1] <= `FUNC_RESET;
        funcQ[2] <= `FUNC_RESET;
        funcQ[3] <= `FUNC_RESET;
        driveQ[0] <= `DRIVE_RESET;
        driveQ[1] <= `DRIVE_RESET;
        ctrlQ <= `CTRL_RESET;
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= acc;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        if (wr) begin
            case (paddr)
                `OFS_FUNC_A:   funcQ[0] <= pwdata[7:0];
                `OFS_FUNC_B:   funcQ[1] <= pwdata[7:0];
                `OFS_FUNC_C:   funcQ[2] <= pwdata[7:0];
                `OFS_FUNC_D:   funcQ[3] <= pwdata[7:0];
                `OFS_DRIVE_AB: driveQ[0] <= pwdata[7:0];
                `OFS_DRIVE_CD: driveQ[1] <= pwdata[7:0];
                `OFS_CTRL:     ctrlQ <= pwdata[7:0];
                `OFS_LEVEL_AB, `OFS_LEVEL_CD, `OFS_CHANGE_AB, `OFS_CHANGE_CD: ;
                default:       pslverr <= 1'b1;
            endcase
        end
        if (rd) begin
            case (paddr)
                `OFS_FUNC_A:    prdata <= {24'h000000, funcQ[0]};
                `OFS_FUNC_B:    prdata <= {24'h000000, funcQ[1]};
                `OFS_FUNC_C:    prdata <= {24'h000000, funcQ[2]};
                `OFS_FUNC_D:    prdata <= {24'h000000, funcQ[3]};
                `OFS_CTRL:      prdata <= {24'h000000, ctrlQ};
                `OFS_LEVEL_AB:  prdata <= {24'h000000, levelAb};
                `OFS_LEVEL_CD:  prdata <= {24'h000000, levelCd};
                `OFS_CHANGE_AB: prdata <= {24'h000000, changeQ[3:0], levelAb[3:0]};
                `OFS_CHANGE_CD: prdata <= {24'h000000, changeQ[7:4], levelCd[3:0]};
                `OFS_DRIVE_AB, `OFS_DRIVE_CD: ;
                default:        pslverr <= 1'b1;
            endcase
        end
    end
end

// ------------------------------------------------------------
// Pin synchroniser and change detectors
// ------------------------------------------------------------
always @(posedge ref_clk) begin
    if (!nrst) begin
        pinSync1Q <= 16'h0000;
        pinSync2Q <= 16'h0000;
        divQ <= 16'h0000;
    end else begin
        pinSync1Q <= pinIn;
        pinSync2Q <= pinSync1Q;
        divQ <= tick ? DIV_LAST[15:0] : divQ - 16'h0001;
    end
end

// Enable bit per channel: chan a,b -> bits 0,1; c,d -> 2,3
wire [7:0] detEn = {ctrlQ[3], ctrlQ[3], ctrlQ[2], ctrlQ[2],
                    ctrlQ[1], ctrlQ[1], ctrlQ[0], ctrlQ[0]};
wire       clrAb = rd && paddr == `OFS_CHANGE_AB;
wire       clrCd = rd && paddr == `OFS_CHANGE_CD;

genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : detect
        // A change must persist over two samples before it counts
        wire confirm = tick && detPins[g] != stableQ[g] && candQ[g] == detPins[g];
        wire clr = (g < 4) ? clrAb : clrCd;
        always @(posedge ref_clk) begin
            if (!nrst) begin
                stableQ[g] <= 1'b0;
                candQ[g] <= 1'b0;
                changeQ[g] <= 1'b0;
            end else begin
                if (tick) begin
                    candQ[g] <= detPins[g];
                end
                if (confirm) begin
                    stableQ[g] <= detPins[g];
                end
                // Set wins over a same-cycle clearing read
                if (confirm && detEn[g]) begin
                    changeQ[g] <= 1'b1;
                end else if (clr) begin
                    changeQ[g] <= 1'b0;
                end
            end
        end
    end
endgenerate

// ------------------------------------------------------------
// Pin drivers and input routing
// ------------------------------------------------------------
reg [15:0] outD;
reg [15:0] oeD;
reg [3:0]  txD;
reg [3:0]  txAltD;
reg [3:0]  rxD;
reg [3:0]  ctsD;
reg [7:0]  code;
reg [7:0]  drv;
reg [2:0]  bp;
reg        flow;
integer    c;

always @* begin
    outD = 16'h0000;
    oeD = 16'hFFFF;
    txD = 4'h0;
    txAltD = 4'h0;
    rxD = 4'h0;
    ctsD = 4'h0;
    code = 8'h00;
    drv = 8'h00;
    bp = 3'h0;
    flow = 1'b0;
    for (c = 0; c < 4; c = c + 1) begin
        code = funcQ[c];
        drv = driveQ[c / 2];
        // Three bits wide: the pin 2 and pin 3 offsets reach bits 6 and 7
        bp = (c % 2 == 1) ? 3'h2 : 3'h0;
        flow = ctrlQ[`CTRL_FLOW_LSB + c];
        // TX, RX and CTS inputs read synchronised pin whatever the code; alt TX clock reads pin 1 only when pin 3 is not an input
        txD[c] = pinSync2Q[4 * c + 3];
        rxD[c] = pinSync2Q[4 * c + 2];
        ctsD[c] = pinSync2Q[4 * c];
        txAltD[c] = (code[7:6] != `CODE_INPUT) ? pinSync2Q[4 * c + 1] : 1'b0;
        // Pin 0
        case (code[1:0])
            `CODE_GPO:   outD[4 * c] = ~drv[bp];
            `CODE_CLK_A: outD[4 * c] = txClk1x[c];
            `CODE_CLK_B: outD[4 * c] = txClk16x[c];
            default:     outD[4 * c] = 1'b0;
        endcase
        // Pin 1; RTS is active low so it equals the inverted bit
        case (code[3:2])
            `CODE_GPO:   outD[4 * c + 1] = ~drv[bp + 3'h1];
            `CODE_CLK_A: outD[4 * c + 1] = (c % 2 == 1) ? timerOut[c / 2] : rxClk16x[c];
            `CODE_CLK_B: outD[4 * c + 1] = rxClk1x[c];
            default:     outD[4 * c + 1] = 1'b0;
        endcase
        // Pin 2
        case (code[5:4])
            `CODE_GPO:   outD[4 * c + 2] = ~drv[bp + 3'h4];
            `CODE_CLK_A: outD[4 * c + 2] = rxClk1x[c];
            `CODE_CLK_B: outD[4 * c + 2] = rxClk16x[c];
            default:     outD[4 * c + 2] = 1'b0;
        endcase
        // Pin 3
        case (code[7:6])
            `CODE_GPO:   outD[4 * c + 3] = ~drv[bp + 3'h5];
            `CODE_CLK_A: outD[4 * c + 3] = txClk16x[c];
            `CODE_CLK_B: outD[4 * c + 3] = txClk1x[c];
            default:     outD[4 * c + 3] = 1'b0;
        endcase
        oeD[4 * c]     = (code[1:0] == `CODE_INPUT);
        oeD[4 * c + 1] = (code[3:2] == `CODE_INPUT);
        oeD[4 * c + 2] = (code[5:4] == `CODE_INPUT);
        oeD[4 * c + 3] = (code[7:6] == `CODE_INPUT);
        // Flow bit is only a mode flag; RTS follows the output bit the host writes
        if (flow) begin
            outD[4 * c + 1] = outD[4 * c + 1];
        end
    end
end

always @(posedge ref_clk) begin
    if (!nrst) begin
        pinOut <= 16'h0000;
        pinOe_n <= 16'hFFFF;
        txClkIn <= 4'h0;
        txClkAltIn <= 4'h0;
        rxClkIn <= 4'h0;
        ctsIn <= 4'h0;
        timerClkIn <= 2'h0;
        changeBid <= 2'h0;
    end else begin
        pinOut <= outD;
        pinOe_n <= oeD;
        txClkIn <= txD;
        txClkAltIn <= txAltD;
        rxClkIn <= rxD;
        ctsIn <= ctsD;
        timerClkIn <= {pinSync2Q[9], pinSync2Q[1]};
        changeBid <= {|changeQ[7:4], |changeQ[3:0]};
    end
end

endmodule // uart_multifunction_io_pins

// ---- pin_lines.sv ----
`timescale 1ns/1ns
// ----------------------
// External pin lines
// ----------------------
module pin_lines (
    input  wire logic [15:0] pinOut,
    input  wire logic [15:0] pinOe_n,
    input  wire logic [15:0] extLevel,
    output wire logic [15:0] pinIn
);
    // A driven pin reads back its own level, so loops through the pad are seen
    assign pinIn = (pinOe_n & extLevel) | (~pinOe_n & pinOut);
endmodule // pin_lines

// ---- io_pins_check_sva.sv ----
`timescale 1ns/1ns
`include "io_pins_map.vh"
// ----------------------
// Port checks
// ----------------------
module io_pins_check (
    input wire        ref_clk,
    input wire        nrst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [15:0] pinIn,
    input wire [15:0] pinOe_n,
    input wire [3:0]  txClkIn,
    input wire [3:0]  rxClkIn,
    input wire [3:0]  ctsIn,
    input wire [1:0]  timerClkIn
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Six quiet samples cover the synchroniser plus the output flop
    sequence quiet;
        $stable(pinIn)[*6];
    endsequence
    sequence readOf(logic [11:0] a);
        pready && !pwrite && !pslverr && paddr == a;
    endsequence
    reset_pins_a: assert property (disable iff (1'b0) !nrst |=> pinOe_n == 16'hFFFF)
        else $error("driver on in reset");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready too long");
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    pin_inputs_a: assert property (quiet |->
        txClkIn == {pinIn[15], pinIn[11], pinIn[7], pinIn[3]}
        && rxClkIn == {pinIn[14], pinIn[10], pinIn[6], pinIn[2]}
        && ctsIn == {pinIn[12], pinIn[8], pinIn[4], pinIn[0]}) else $error("input path");
    timer_clk_a: assert property (quiet |-> timerClkIn == {pinIn[9], pinIn[1]})
        else $error("timer clock");
    level_read_a: assert property (quiet ##0 readOf(`OFS_LEVEL_AB) |->
        prdata == {24'h0, pinIn[7:6], pinIn[3:2], pinIn[5:4], pinIn[1:0]}) else $error("level");
    change_low_a: assert property (quiet ##0 readOf(`OFS_CHANGE_AB) |->
        prdata[3:0] == {pinIn[5:4], pinIn[1:0]}) else $error("change low bits");
endmodule // io_pins_check
bind uart_multifunction_io_pins io_pins_check i_io_pins_check (.ref_clk, .nrst, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .pinIn, .pinOe_n, .txClkIn,
    .rxClkIn, .ctsIn, .timerClkIn);

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "io_pins_map.vh"
// ----------------------
// Bench
// ----------------------
module testbench;
    logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] pinIn, pinOut, pinOe_n, extLevel;
    logic [3:0]  txClk1x, txClk16x, rxClk1x, rxClk16x, txClkIn, txClkAltIn, rxClkIn, ctsIn;
    logic [1:0]  timerOut, timerClkIn, changeBid;
    int          miscompares, testsRun;
    // Address, written byte, expected pin levels of that pair
    logic [27:0] rows[4] = '{28'h00C0FCC, 28'h00C30F3, 28'h01CC03F, 28'h01C05EE};
    uart_multifunction_io_pins i_uart_multifunction_io_pins (.ref_clk, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe_n,
        .txClk1x, .txClk16x, .rxClk1x, .rxClk16x, .timerOut, .txClkIn, .txClkAltIn, .rxClkIn,
        .ctsIn, .timerClkIn, .changeBid);
    pin_lines i_pin_lines (.pinOut, .pinOe_n, .extLevel, .pinIn);
    task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] x, string what);
        apb(1'b0, a, 8'h00);
        check(q, {24'h0, x}, what);
    endtask
    task automatic setAll(logic [7:0] code);
        for (int i = 0; i < 4; i++) apb(1'b1, 12'(`OFS_FUNC_A + 4 * i), code);
        repeat (6) @(posedge ref_clk);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, extLevel} = '0;
        {txClk1x, txClk16x, rxClk1x, rxClk16x, timerOut, miscompares, testsRun} = '0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        check(pinOe_n, 32'hFFFF, "oe reset");
        for (int i = 0; i < 4; i++) rd(12'(`OFS_FUNC_A + 4 * i), 8'h00, "fn reset");
        setAll(8'h55);
        rd(`OFS_FUNC_C, 8'h55, "fn readback");
        foreach (rows[i]) begin
            apb(1'b1, rows[i][27:16], rows[i][15:8]);
            repeat (2) @(posedge ref_clk);
            check(rows[i][20] ? pinOut[15:8] : pinOut[7:0], rows[i][7:0], "gpo");
        end
        check(pinOe_n, 32'h0, "oe gpo");
        rd(`OFS_LEVEL_AB, 8'hCF, "level driven ab");
        rd(`OFS_LEVEL_CD, 8'hFA, "level driven cd");
        apb(1'b0, 12'h100, 8'h00);
        check(e, 32'h1, "unmapped");
        extLevel <= 16'h8412;
        setAll(8'h00);
        check(pinOe_n, 32'hFFFF, "oe input");
        rd(`OFS_LEVEL_AB, 8'h06, "level ab");
        rd(`OFS_LEVEL_CD, 8'h90, "level cd");
        rd(`OFS_CHANGE_AB, 8'h06, "change low");
        check({txClkAltIn, txClkIn, rxClkIn, ctsIn, timerClkIn}, 32'h2109, "inputs");
        apb(1'b1, `OFS_FUNC_A, 8'h80);
        repeat (6) @(posedge ref_clk);
        check(txClkAltIn, 32'h1, "alt clock");
        {txClk1x, rxClk1x, timerOut} <= 10'h3F1;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `OFS_FUNC_A, k ? 8'hFF : 8'hAA);
            apb(1'b1, `OFS_FUNC_B, k ? 8'hFF : 8'hAA);
            repeat (2) @(posedge ref_clk);
            check(pinOut[7:0], k ? 8'h88 : 8'h31, "clock out");
        end
        extLevel <= 16'h0;
        setAll(8'h00);
        // Flow bits stay clear so no host write races the receiver
        apb(1'b1, `OFS_CTRL, 8'h01);
        repeat (4000) @(posedge ref_clk);
        apb(1'b0, `OFS_CHANGE_AB, 8'h00);
        extLevel <= 16'h0001;
        repeat (4000) @(posedge ref_clk);
        check(changeBid, 32'h1, "bid");
        rd(`OFS_CHANGE_AB, 8'h11, "flag set");
        rd(`OFS_CHANGE_AB, 8'h01, "flag clear");
        repeat (2) @(posedge ref_clk);
        check(changeBid, 32'h0, "bid clear");
        // Pin 0b has its detector off; pin 1a only glitches
        extLevel <= 16'h0013;
        repeat (100) @(posedge ref_clk);
        extLevel <= 16'h0011;
        repeat (4000) @(posedge ref_clk);
        rd(`OFS_CHANGE_AB, 8'h05, "no flag");
        wrap_up();
    end
endmodule // testbench
